// [common/adrs_pkg.sv]
package adrs_pkg;

  // ==================================================================
  // addresses and widths
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] DATA_LAST_ADDR = 8'h06;
  localparam logic [7:0] FULL_STEP = 8'h01;
  localparam logic [7:0] FAST_STEP = 8'h02;
  localparam int NUM_AXES = 3;
  localparam int AXIS_X = 0;
  localparam int AXIS_Y = 1;
  localparam int AXIS_Z = 2;
  localparam int FIFO_CNT_W = 6;
  localparam logic [1:0] FIFO_MODE_OFF = 2'h0;

  // ==================================================================
  // reset values
  localparam logic [2:0] AXIS_MASK_RESET = 3'h0;
  localparam logic [2:0] AXIS_MASK_ALL = 3'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==================================================================
  // status byte layouts, msb first
  typedef struct packed {
    logic zyx_overwrite;
    logic [2:0] axis_overwrite;
    logic zyx_ready;
    logic [2:0] axis_ready;
  } adrs_data_ready_status_t;

  typedef struct packed {
    logic overflow;
    logic watermark;
    logic [FIFO_CNT_W-1:0] count;
  } adrs_fifo_status_t;

  typedef struct packed {
    logic req;
    logic fast;
  } adrs_rd_req_t;

  // ==================================================================
  // burst tracking, gray along idle, burst, hold
  typedef enum logic [1:0] {
    ADRS_IDLE = 2'b00,
    ADRS_BURST = 2'b01,
    ADRS_HOLD = 2'b11
  } adrs_state_t;

  function automatic logic any_bit(input logic [2:0] v);
    any_bit = |v;
  endfunction

endpackage

// [rtl/adrs_axis_flag.sv]
`timescale 1ns/1ns
`default_nettype none
module adrs_axis_flag
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic done_in,
  input wire logic hi_read_in,
  output logic ready_out,
  output logic overwrite_out,
  output logic lost_out
);
  import adrs_pkg::*;

  // ==================================================================
  // per-axis flags
  logic ready;
  logic overwrite;
  logic next_ready;
  logic next_overwrite;
  logic lost;

  always_comb
  begin
    // a read in the same cycle means the old value was taken
    lost = done_in & ready & ~hi_read_in;
    // set wins over clear so no completion is missed
    next_ready = done_in | (ready & ~hi_read_in);
    next_overwrite = lost | (overwrite & ~hi_read_in);
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ready <= 1'b0;
      overwrite <= 1'b0;
    end
    else
    begin
      ready <= next_ready;
      overwrite <= next_overwrite;
    end
  end

  assign ready_out = ready;
  assign overwrite_out = overwrite;
  assign lost_out = lost;

endmodule
`default_nettype wire

// [rtl/adrs_addr_ptr.sv]
`timescale 1ns/1ns
`default_nettype none
module adrs_addr_ptr
#(
  parameter logic [7:0] LAST_ADDR = adrs_pkg::DATA_LAST_ADDR
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [7:0] load_addr_in,
  input wire logic home_in,
  input wire logic step_in,
  input wire logic fast_in,
  output logic [7:0] ptr_out
);
  import adrs_pkg::*;

  // ==================================================================
  // auto-increment pointer
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [8:0] sum;
  logic [7:0] step;

  always_comb
  begin
    // fast reads skip the low bytes once past the status byte
    step = (fast_in && ptr != STATUS_ADDR) ? FAST_STEP : FULL_STEP;
    sum = {1'b0, ptr} + {1'b0, step};
    next_ptr = ptr;
    if (load_in)
      next_ptr = load_addr_in;
    else if (home_in)
      next_ptr = STATUS_ADDR;
    else if (step_in)
    begin
      // wrap back so a burst restarts at the status byte
      if (sum > {1'b0, LAST_ADDR})
        next_ptr = STATUS_ADDR;
      else
        next_ptr = sum[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ptr <= STATUS_ADDR;
    else
      ptr <= next_ptr;
  end

  assign ptr_out = ptr;

endmodule
`default_nettype wire

// [rtl/adrs_status_top.sv]
`timescale 1ns/1ns
`default_nettype none
module adrs_status_top
#(
  parameter logic [7:0] LAST_ADDR = adrs_pkg::DATA_LAST_ADDR
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] axis_done_in,
  input wire logic [2:0] axis_enable_in,
  input wire logic [2:0] hi_byte_read_in,
  input wire logic [1:0] fifo_mode_in,
  input wire adrs_pkg::adrs_fifo_status_t fifo_status_in,
  input wire logic spi_mode_in,
  input wire logic burst_start_in,
  input wire logic [7:0] start_addr_in,
  input wire logic i2c_stop_in,
  input wire logic burst_end_in,
  input wire adrs_pkg::adrs_rd_req_t rd_req_in,
  input wire logic [7:0] ext_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic [7:0] ptr_out,
  output adrs_pkg::adrs_data_ready_status_t data_ready_status_out,
  output logic burst_active_out
);
  import adrs_pkg::*;

  // ==================================================================
  // parameter checks
  // refuse settings that the fixed-width ports cannot serve
  if (LAST_ADDR == STATUS_ADDR)
  begin : g_bad_last
    $error("last data address must lie above the status address");
  end

  if (NUM_AXES != 3)
  begin : g_bad_axes
    $error("axis ports carry exactly three axes");
  end

  // both layouts share the one byte lane at the status address
  if ($bits(adrs_data_ready_status_t) != 8 || $bits(adrs_fifo_status_t) != 8)
  begin : g_bad_layout
    $error("status layouts must fill exactly one byte");
  end

  // the count must reach the full depth of thirty-two samples
  if (FIFO_CNT_W < 6)
  begin : g_bad_count
    $error("fifo sample count field is too narrow");
  end

  // ==================================================================
  // per-axis flags
  logic [2:0] axis_ready;
  logic [2:0] axis_overwrite;
  logic [2:0] axis_lost;

  // one instance per axis, so each clears on its own high-byte read
  for (genvar i = 0; i < NUM_AXES; i++)
  begin : g_axis
    adrs_axis_flag u_flag
    (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .done_in(axis_done_in[i]),
      .hi_read_in(hi_byte_read_in[i]),
      .ready_out(axis_ready[i]),
      .overwrite_out(axis_overwrite[i]),
      .lost_out(axis_lost[i])
    );
  end

  // ==================================================================
  // combined flags
  // a clear only needs all three high bytes read once since the last
  // new sample; reads before the sample do not count toward the clear
  logic zyx_ready;
  logic zyx_overwrite;
  logic [2:0] read_seen;
  logic next_zyx_ready;
  logic next_zyx_overwrite;
  logic [2:0] next_read_seen;
  logic [2:0] seen_now;
  logic all_read;
  logic new_sample;
  logic any_lost;
  logic [2:0] enabled_done;

  always_comb
  begin
    // per-axis bits are not gated; enable only gates the combined ready set
    enabled_done = axis_done_in & axis_enable_in;
    new_sample = any_bit(enabled_done);
    any_lost = any_bit(axis_lost);
    seen_now = read_seen | hi_byte_read_in;
    all_read = (seen_now == AXIS_MASK_ALL);
    // an overwritten axis must be read again, even while disabled
    next_read_seen = seen_now & ~axis_lost;
    if (new_sample)
      next_read_seen = hi_byte_read_in & ~enabled_done;
    else if (all_read)
      next_read_seen = AXIS_MASK_RESET;
    // set wins over the clear in the same cycle
    next_zyx_ready = new_sample | (zyx_ready & ~all_read);
    next_zyx_overwrite = any_lost | (zyx_overwrite & ~all_read);
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      zyx_ready <= 1'b0;
      zyx_overwrite <= 1'b0;
      read_seen <= AXIS_MASK_RESET;
    end
    else
    begin
      zyx_ready <= next_zyx_ready;
      zyx_overwrite <= next_zyx_overwrite;
      read_seen <= next_read_seen;
    end
  end

  // ==================================================================
  // status byte
  adrs_data_ready_status_t data_ready_status;
  logic [7:0] status_byte;
  adrs_fifo_status_t fifo_byte;

  always_comb
  begin
    data_ready_status.zyx_overwrite = zyx_overwrite;
    data_ready_status.axis_overwrite = axis_overwrite;
    data_ready_status.zyx_ready = zyx_ready;
    data_ready_status.axis_ready = axis_ready;
    // fifo contents come from the fifo engine, only muxed here
    fifo_byte.overflow = fifo_status_in.overflow;
    fifo_byte.watermark = fifo_status_in.watermark;
    fifo_byte.count = fifo_status_in.count;
    // live flags, not the mirror, so a read never returns a stale byte
    if (fifo_mode_in == FIFO_MODE_OFF)
      status_byte = data_ready_status;
    else
      status_byte = fifo_byte;
  end

  // ==================================================================
  // burst tracking
  // in spi the pointer is held across the end of a burst; in i2c
  // the stop condition sends it home
  adrs_state_t state;
  adrs_state_t next_state;
  logic home;
  logic i2c_stop;

  // a stop only means something on the i2c link
  assign i2c_stop = !spi_mode_in && i2c_stop_in;

  always_comb
  begin
    next_state = state;
    home = 1'b0;
    // a new start wins in every state and reloads the pointer
    case (state)
      ADRS_IDLE:
      begin
        if (burst_start_in)
          next_state = ADRS_BURST;
      end
      ADRS_BURST:
      begin
        if (burst_start_in)
          next_state = ADRS_BURST;
        else if (i2c_stop)
        begin
          next_state = ADRS_IDLE;
          home = 1'b1;
        end
        else if (spi_mode_in && burst_end_in)
          next_state = ADRS_HOLD;
      end
      // hold keeps the pointer; the burst reopens only on a new start, which reloads it
      ADRS_HOLD:
      begin
        if (burst_start_in)
          next_state = ADRS_BURST;
        else if (!spi_mode_in)
          next_state = ADRS_IDLE;
      end
      default:
        next_state = ADRS_IDLE;
    endcase
    // a stop outside a burst still homes the pointer in i2c
    if (i2c_stop)
      home = 1'b1;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      state <= ADRS_IDLE;
    else
      state <= next_state;
  end

  // ==================================================================
  // pointer
  logic rd_take;
  logic [7:0] ptr;

  // reads only advance while a burst is open
  // a read in the load cycle is dropped; the pointer is reloading
  assign rd_take = rd_req_in.req && (state == ADRS_BURST) && !burst_start_in;

  adrs_addr_ptr #(
    .LAST_ADDR(LAST_ADDR)
  ) u_ptr
  (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .load_in(burst_start_in),
    .load_addr_in(start_addr_in),
    .home_in(home),
    .step_in(rd_take),
    .fast_in(rd_req_in.fast),
    .ptr_out(ptr)
  );

  // ==================================================================
  // read data
  // reading the status byte has no side effect on any flag
  // the mirror trails the flags by one edge so the output is a flop
  logic [7:0] rd_data;
  logic rd_valid;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  adrs_data_ready_status_t status_mirror;
  adrs_data_ready_status_t next_status_mirror;
  logic burst_active;
  logic next_burst_active;

  always_comb
  begin
    next_rd_valid = rd_take;
    next_rd_data = rd_data;
    if (rd_take)
    begin
      if (ptr == STATUS_ADDR)
        next_rd_data = status_byte;
      else
        next_rd_data = ext_data_in;
    end
    next_status_mirror = data_ready_status;
    next_burst_active = (next_state == ADRS_BURST);
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rd_data <= BYTE_RESET;
      rd_valid <= 1'b0;
      status_mirror <= BYTE_RESET;
      burst_active <= 1'b0;
    end
    else
    begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      status_mirror <= next_status_mirror;
      burst_active <= next_burst_active;
    end
  end

  // ==================================================================
  // outputs
  // all straight from registers, nothing combinational on the pins
  assign rd_data_out = rd_data;
  assign rd_valid_out = rd_valid;
  assign ptr_out = ptr;
  assign data_ready_status_out = status_mirror;
  assign burst_active_out = burst_active;

endmodule
`default_nettype wire

// [sim/adrs_sample_model.sv]
`timescale 1ns/1ns
`default_nettype none
module adrs_sample_model
(
  input wire logic [7:0] ptr_in,
  output logic [7:0] data_out
);
  // ==========
  // sample registers, distinct per address so a wrong pointer shows
  assign data_out = ptr_in ^ 8'ha5;
endmodule
`default_nettype wire

// [sim/adrs_status_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module adrs_status_chk
import adrs_pkg::*;
#(
  parameter logic [7:0] LAST_ADDR = adrs_pkg::DATA_LAST_ADDR
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] axis_done_in,
  input wire logic [2:0] axis_enable_in,
  input wire logic [2:0] hi_byte_read_in,
  input wire logic [1:0] fifo_mode_in,
  input wire adrs_pkg::adrs_fifo_status_t fifo_status_in,
  input wire logic spi_mode_in,
  input wire logic burst_start_in,
  input wire logic [7:0] start_addr_in,
  input wire logic i2c_stop_in,
  input wire logic burst_end_in,
  input wire adrs_pkg::adrs_rd_req_t rd_req_in,
  input wire logic [7:0] ext_data_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic [7:0] ptr_out,
  input wire adrs_pkg::adrs_data_ready_status_t data_ready_status_out,
  input wire logic burst_active_out
);
  logic take;
  logic [8:0] nxt;
  assign take = rd_req_in.req && burst_active_out && !burst_start_in;
  // ==========
  // expected pointer step, wider so overshoot is visible
  always_comb
  begin
    nxt = (ptr_out == 8'h00 || !rd_req_in.fast) ? ptr_out + 9'h001 : ptr_out + 9'h002;
    if (nxt > {1'b0, LAST_ADDR})
      nxt = 9'h000;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========
  // assertions
  a_ready_set: assert property (axis_done_in != 3'h0 |->
    ##2 (data_ready_status_out.axis_ready & $past(axis_done_in, 2)) == $past(axis_done_in, 2))
    else $error("axis ready not set");
  a_ready_clear: assert property ((hi_byte_read_in & ~axis_done_in) != 3'h0 |->
    ##2 (data_ready_status_out.axis_ready & $past(hi_byte_read_in & ~axis_done_in, 2)) == 3'h0)
    else $error("axis ready not cleared");
  a_ow_clear: assert property ((hi_byte_read_in & ~axis_done_in) != 3'h0 |->
    ##2 (data_ready_status_out.axis_overwrite & $past(hi_byte_read_in & ~axis_done_in, 2)) == 3'h0)
    else $error("axis overwrite not cleared");
  a_ow_combined: assert property (data_ready_status_out.axis_overwrite != 3'h0 |->
    data_ready_status_out.zyx_overwrite) else $error("combined overwrite missing");
  a_fifo_alias: assert property (take && ptr_out == 8'h00 && fifo_mode_in != 2'h0 |=>
    rd_valid_out && rd_data_out == $past(fifo_status_in)) else $error("fifo byte not at status");
  a_status_byte: assert property (take && ptr_out == 8'h00 && fifo_mode_in == 2'h0 |=>
    rd_valid_out && rd_data_out == data_ready_status_out) else $error("status byte not at status");
  a_ext_data: assert property (take && ptr_out != 8'h00 |=>
    rd_valid_out && rd_data_out == $past(ext_data_in)) else $error("sample byte wrong");
  a_ptr_step: assert property (take && !(i2c_stop_in && !spi_mode_in) |=>
    ptr_out == $past(nxt[7:0])) else $error("pointer step wrong");
  a_no_valid: assert property (!take |=> !rd_valid_out) else $error("valid without request");
  a_i2c_home: assert property (i2c_stop_in && !spi_mode_in && !burst_start_in |=>
    ptr_out == 8'h00 && !burst_active_out) else $error("pointer not homed on stop");
  c_status_read: cover property (take && ptr_out == 8'h00);
  c_overwrite: cover property (data_ready_status_out == 8'h99);
  c_stop: cover property (i2c_stop_in && !spi_mode_in);
endmodule
bind adrs_status_top adrs_status_chk #(.LAST_ADDR(LAST_ADDR)) u_chk (.*);
`default_nettype wire

// [sim/accel_data_ready_status_test.sv]
`timescale 1ns/1ns
`default_nettype none
module accel_data_ready_status_test;
  import adrs_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] done = 3'h0, en = 3'h7, hi = 3'h0;
  logic [1:0] fmode = 2'h0;
  adrs_fifo_status_t fstat = 8'h00;
  adrs_rd_req_t req = 2'h0;
  logic spi = 1'b0, bstart = 1'b0, stop = 1'b0, bend = 1'b0, rvalid, bact;
  logic [7:0] saddr = 8'h00, ext, rdata, ptr;
  adrs_data_ready_status_t st;
  int n_fail = 0, tests_run = 0, cycles = 0;
  always #20 clk_in = ~clk_in;
  adrs_status_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .axis_done_in(done), .axis_enable_in(en),
    .hi_byte_read_in(hi), .fifo_mode_in(fmode), .fifo_status_in(fstat), .spi_mode_in(spi),
    .burst_start_in(bstart), .start_addr_in(saddr), .i2c_stop_in(stop), .burst_end_in(bend),
    .rd_req_in(req), .ext_data_in(ext), .rd_data_out(rdata), .rd_valid_out(rvalid), .ptr_out(ptr),
    .data_ready_status_out(st), .burst_active_out(bact));
  adrs_sample_model u_model (.ptr_in(ptr), .data_out(ext));
  // ==========
  // tasks, all driving on the falling edge
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(input logic [2:0] d, input logic [2:0] h);
    @(negedge clk_in);
    done = d;
    hi = h;
    @(negedge clk_in);
    done = 3'h0;
    hi = 3'h0;
    @(negedge clk_in);
  endtask
  task automatic start(input logic [7:0] a);
    @(negedge clk_in);
    bstart = 1'b1;
    saddr = a;
    @(negedge clk_in);
    bstart = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic fast, input logic [7:0] exp);
    @(negedge clk_in);
    req = {1'b1, fast};
    @(negedge clk_in);
    req = 2'h0;
    chk8("rd_valid", 8'h01, {7'h00, rvalid});
    chk8("rd_data", exp, rdata);
  endtask
  task automatic ctl(input logic s, input logic e);
    @(negedge clk_in);
    stop = s;
    bend = e;
    @(negedge clk_in);
    stop = 1'b0;
    bend = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========
  // hang guard, runs need well under a thousand cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end
  // ==========
  // scenarios
  initial
  begin
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    chk8("status", 8'h00, st);
    chk8("ptr", 8'h00, ptr);
    pulse(3'h1, 3'h0);
    chk8("status", 8'h09, st);
    pulse(3'h1, 3'h0);
    chk8("status", 8'h99, st);
    pulse(3'h0, 3'h1);
    chk8("status", 8'h88, st);
    pulse(3'h0, 3'h2);
    pulse(3'h0, 3'h4);
    chk8("status", 8'h00, st);
    pulse(3'h7, 3'h0);
    chk8("status", 8'h0f, st);
    pulse(3'h2, 3'h2);
    chk8("status", 8'h0f, st);
    start(8'h00);
    rd(1'b1, 8'h0f);
    rd(1'b1, 8'h01 ^ 8'ha5);
    rd(1'b1, 8'h03 ^ 8'ha5);
    rd(1'b0, 8'h05 ^ 8'ha5);
    rd(1'b1, 8'h06 ^ 8'ha5);
    chk8("ptr", 8'h00, ptr);
    chk8("status", 8'h0f, st);
    fstat = 8'hc5;
    for (int m = 0; m < 4; m++)
    begin
      start(8'h00);
      fmode = m[1:0];
      rd(1'b0, (m == 0) ? 8'h0f : 8'hc5);
    end
    fmode = 2'h0;
    start(8'h03);
    ctl(1'b1, 1'b0);
    chk8("ptr", 8'h00, ptr);
    chk8("burst", 8'h00, {7'h00, bact});
    spi = 1'b1;
    start(8'h03);
    rd(1'b0, 8'h03 ^ 8'ha5);
    ctl(1'b1, 1'b1);
    chk8("ptr", 8'h04, ptr);
    chk8("burst", 8'h00, {7'h00, bact});
    @(negedge clk_in);
    req = 2'h2;
    @(negedge clk_in);
    req = 2'h0;
    chk8("rd_valid", 8'h00, {7'h00, rvalid});
    chk8("ptr", 8'h04, ptr);
    start(8'h05);
    rd(1'b0, 8'h05 ^ 8'ha5);
    pulse(3'h0, 3'h7);
    chk8("status", 8'h00, st);
    en = 3'h0;
    pulse(3'h1, 3'h0);
    chk8("status", 8'h01, st);
    pulse(3'h1, 3'h0);
    chk8("status", 8'h91, st);
    rstn_in = 1'b0;
    @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    chk8("status", 8'h00, st);
    chk8("ptr", 8'h00, ptr);
    chk8("burst", 8'h00, {7'h00, bact});
    finish_test();
  end
endmodule
`default_nettype wire
